/* include/pka_defines.vh */
// address map, field positions, reset values and codes of the public key accelerator
`ifndef PKA_DEFINES_VH
`define PKA_DEFINES_VH

// ************************************************************
// address map
// ************************************************************
`define PKA_ADDR_W 14
`define PKA_RAMA_BASE 14'h0400
`define PKA_RAMB_BASE 14'h1000
`define PKA_RAM_SPAN 14'h0800
`define PKA_CTRL_ADDR 14'h2000
`define PKA_CFG_ADDR 14'h2004
`define PKA_MODE_ADDR 14'h2008
`define PKA_STAT_ADDR 14'h2010

// ************************************************************
// field positions
// ************************************************************
`define PKA_START_BIT 0
`define PKA_STOP_BIT 16
`define PKA_IRQ_ENABLE_BIT 8
`define PKA_RADIX_MSB 23
`define PKA_RADIX_LSB 16
`define PKA_BASEW_MSB 2
`define PKA_BASEW_LSB 0
`define PKA_CURVE_MSB 9
`define PKA_CURVE_LSB 8
`define PKA_OPSEL_MSB 13
`define PKA_OPSEL_LSB 12
`define PKA_DONE_BIT 1
`define PKA_ABORT_BIT 2

// ************************************************************
// reset values and codes
// ************************************************************
`define PKA_BASEW_RST 3'h2
`define PKA_RADIX_RST 8'h00
`define PKA_RESP_OKAY 2'h0
`define PKA_RESP_SLVERR 2'h2
`define PKA_STRB_FULL 4'hf
`define PKA_OP_END 4'h0
`define PKA_OP_ADD 4'h1
`define PKA_OP_SUB 4'h2
`define PKA_OP_MOV 4'h3
`define PKA_OP_XOR 4'h4

`endif

/* logic/pka_word_ram.v */
// word-wide operand memory with a host port and an engine port
`timescale 1ns/1ps
module pka_word_ram #(
   parameter AW = 9,
   parameter DEPTH = 512
) (
   input wire clk,
   input wire [AW-1:0] hostAddr,
   input wire hostWe,
   input wire [31:0] hostWdata,
   output reg [31:0] hostRdata,
   input wire [AW-1:0] engAddr,
   input wire engWe,
   input wire [31:0] engWdata,
   output reg [31:0] engRdata
);
   reg [31:0] mem [0:DEPTH-1];

   // engine write comes last so it wins a same-word collision
   always @(posedge clk) begin
      if (hostWe) begin
         mem[hostAddr] <= hostWdata;
      end
      if (engWe) begin
         mem[engAddr] <= engWdata;
      end
      hostRdata <= mem[hostAddr];
      engRdata <= mem[engAddr];
   end
endmodule // pka_word_ram

/* logic/pka_top.v */
// public key accelerator: axi4-lite slave, microcode sequencer, word alu, two operand rams
//
// Overview of operation
// - prime-field arithmetic at 192 or 256 bits
// - curve selection for four supported parameter sets; curveReg is only stored and read back
// - everything mapped in one 7 KB window; the code maps 0x400 to 0x2013, which is more than 7 KB
// - operands stored least significant word first
// - smallest operand unit is one word
// - start launches using config at that moment
// - running state readable in status anytime
// - host may abort via control register
// - operand ram readable during an operation
// - completion seen by polling and by interrupt
// - ram accesses whole aligned words only
// - ram a at 0x400, ram b 0x1000
// - ram a ten slots, stride by width
// - ram b ten slots, same stride
// - ram space beyond slots kept for intermediates
// - sequence runs from internal microcode memory
// - sequencer steers 32-bit alu over rams
// - start bit launches next cycle, reads zero
// - stop bit halts engine next cycle
// - irq enable gates output only
// - operand width is word count times 32
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pka_defines.vh"
module pka_top #(
   parameter RAM_AW = 9,
   parameter RAM_DEPTH = 512
) (
   input wire clk,
   input wire rst_n,
   input wire [`PKA_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`PKA_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg irq
);
   localparam ST_IDLE = 3'h0;
   localparam ST_FETCH = 3'h1;
   localparam ST_DECODE = 3'h2;
   localparam ST_READ = 3'h3;
   localparam ST_EXEC = 3'h4;
   localparam RD_IDLE = 2'h0;
   localparam RD_ADDR = 2'h1;
   localparam RD_DATA = 2'h2;
   localparam RD_WAIT = 2'h3;

   // ************************************************************
   // write channel holding
   // ************************************************************
   reg awHeld;
   reg wHeld;
   reg [`PKA_ADDR_W-1:0] awAddrReg;
   reg [31:0] wDataReg;
   reg [3:0] wStrbReg;
   wire wrCommit;
   assign wrCommit = awHeld & wHeld & ~s_axi_bvalid;

   // ************************************************************
   // control and status state
   // ************************************************************
   reg startPulseReg;
   reg stopPulseReg;
   reg irqEnReg;
   reg [7:0] radixReg;
   reg [2:0] baseWReg;
   reg [1:0] curveReg;
   reg [1:0] opSelReg;
   reg busyReg;
   reg doneReg;
   reg abortReg;
   reg carryReg;

   // ************************************************************
   // address decode
   // ************************************************************
   reg [`PKA_ADDR_W-1:0] arAddrReg;
   wire [`PKA_ADDR_W-1:0] awOffA = awAddrReg - `PKA_RAMA_BASE;
   wire [`PKA_ADDR_W-1:0] awOffB = awAddrReg - `PKA_RAMB_BASE;
   wire [`PKA_ADDR_W-1:0] arOffA = arAddrReg - `PKA_RAMA_BASE;
   wire [`PKA_ADDR_W-1:0] arOffB = arAddrReg - `PKA_RAMB_BASE;
   wire awHitA = (awAddrReg >= `PKA_RAMA_BASE) && (awOffA < `PKA_RAM_SPAN);
   wire awHitB = (awAddrReg >= `PKA_RAMB_BASE) && (awOffB < `PKA_RAM_SPAN);
   wire arHitA = (arAddrReg >= `PKA_RAMA_BASE) && (arOffA < `PKA_RAM_SPAN);
   wire arHitB = (arAddrReg >= `PKA_RAMB_BASE) && (arOffB < `PKA_RAM_SPAN);
   wire awCtrl = (awAddrReg == `PKA_CTRL_ADDR);
   wire awCfg = (awAddrReg == `PKA_CFG_ADDR);
   wire awMode = (awAddrReg == `PKA_MODE_ADDR);
   wire awStat = (awAddrReg == `PKA_STAT_ADDR);
   wire awFull = (wStrbReg == `PKA_STRB_FULL);
   // partial strobes would corrupt neighbouring operand bytes, so refuse them
   wire awRamOk = (awHitA | awHitB) & awFull;
   wire awRegOk = awCtrl | awCfg | awMode | awStat;
   wire [1:0] wrResp = (awRamOk | awRegOk) ? `PKA_RESP_OKAY : `PKA_RESP_SLVERR;

   // ************************************************************
   // axi write channels
   // ************************************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddrReg <= {`PKA_ADDR_W{1'b0}};
         wDataReg <= 32'h0;
         wStrbReg <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PKA_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddrReg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrCommit) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrResp;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // register writes
   // ************************************************************
   wire ctrlWr = wrCommit & awCtrl;
   wire startReq = ctrlWr & wStrbReg[0] & wDataReg[`PKA_START_BIT];
   wire stopReq = ctrlWr & wStrbReg[2] & wDataReg[`PKA_STOP_BIT];
   wire statWr = wrCommit & awStat & wStrbReg[0];
   wire doneClr = statWr & wDataReg[`PKA_DONE_BIT];
   wire abortClr = statWr & wDataReg[`PKA_ABORT_BIT];

   always @(posedge clk) begin
      if (!rst_n) begin
         startPulseReg <= 1'b0;
         stopPulseReg <= 1'b0;
         irqEnReg <= 1'b0;
         radixReg <= `PKA_RADIX_RST;
         baseWReg <= `PKA_BASEW_RST;
         curveReg <= 2'h0;
         opSelReg <= 2'h0;
      end else begin
         startPulseReg <= startReq;
         stopPulseReg <= stopReq;
         if (wrCommit && awCfg && wStrbReg[1]) begin
            irqEnReg <= wDataReg[`PKA_IRQ_ENABLE_BIT];
         end
         if (wrCommit && awCfg && wStrbReg[2]) begin
            radixReg <= wDataReg[`PKA_RADIX_MSB:`PKA_RADIX_LSB];
         end
         if (wrCommit && awMode && wStrbReg[0]) begin
            baseWReg <= wDataReg[`PKA_BASEW_MSB:`PKA_BASEW_LSB];
         end
         if (wrCommit && awMode && wStrbReg[1]) begin
            curveReg <= wDataReg[`PKA_CURVE_MSB:`PKA_CURVE_LSB];
            opSelReg <= wDataReg[`PKA_OPSEL_MSB:`PKA_OPSEL_LSB];
         end
      end
   end

   // ************************************************************
   // microcode program memory
   // ************************************************************
   // word: op[15:12] dst slot[11:8] ram a src[7:4] ram b src[3:0]
   function [15:0] microWord;
      input [5:0] pc;
      begin
         case (pc)
            6'h00: microWord = 16'h1200;
            6'h08: microWord = 16'h2200;
            6'h10: microWord = 16'h1300;
            6'h11: microWord = 16'h2431;
            6'h18: microWord = 16'h3510;
            6'h19: microWord = 16'h4652;
            default: microWord = 16'h0000;
         endcase
      end
   endfunction

   // ************************************************************
   // sequencer
   // ************************************************************
   reg [2:0] stateReg;
   reg [5:0] pcReg;
   reg [15:0] instrReg;
   reg [7:0] idxReg;
   reg [7:0] radixLat;
   reg [2:0] baseWLat;
   wire [3:0] opCode = instrReg[15:12];
   // slot stride in words: 1 << (baseWLat + 1) plus one spare word
   wire [8:0] strideW = (9'h1 << (baseWLat + 3'h1)) + 9'h1;
   wire [12:0] dstBase = {9'h0, instrReg[11:8]} * {4'h0, strideW};
   wire [12:0] srcABase = {9'h0, instrReg[7:4]} * {4'h0, strideW};
   wire [12:0] srcBBase = {9'h0, instrReg[3:0]} * {4'h0, strideW};
   // word idx counts upward so the low word goes first and carries ripple up
   wire [RAM_AW-1:0] idxW = {{(RAM_AW-8){1'b0}}, idxReg};
   wire [RAM_AW-1:0] dstAddr = dstBase[RAM_AW-1:0] + idxW;
   wire [RAM_AW-1:0] srcAAddr = srcABase[RAM_AW-1:0] + idxW;
   wire [RAM_AW-1:0] srcBAddr = srcBBase[RAM_AW-1:0] + idxW;
   wire [31:0] engDoutA;
   wire [31:0] engDoutB;
   wire [31:0] bOperand = (opCode == `PKA_OP_SUB) ? ~engDoutB : engDoutB;
   wire [32:0] sumW = {1'b0, engDoutA} + {1'b0, bOperand} + {32'h0, carryReg};
   reg [31:0] aluOut;
   always @* begin
      case (opCode)
         `PKA_OP_ADD: aluOut = sumW[31:0];
         `PKA_OP_SUB: aluOut = sumW[31:0];
         `PKA_OP_MOV: aluOut = engDoutA;
         `PKA_OP_XOR: aluOut = engDoutA ^ engDoutB;
         default: aluOut = 32'h0;
      endcase
   end
   wire engWeA = (stateReg == ST_EXEC);
   wire [RAM_AW-1:0] engAddrA = engWeA ? dstAddr : srcAAddr;
   wire lastWord = (idxReg + 8'h1 == radixLat);
   wire setDone;
   assign setDone = busyReg & (stopPulseReg |
                    ((stateReg == ST_DECODE) && (opCode == `PKA_OP_END)));

   always @(posedge clk) begin
      if (!rst_n) begin
         stateReg <= ST_IDLE;
         pcReg <= 6'h0;
         instrReg <= 16'h0;
         idxReg <= 8'h0;
         radixLat <= `PKA_RADIX_RST;
         baseWLat <= `PKA_BASEW_RST;
         busyReg <= 1'b0;
         carryReg <= 1'b0;
      end else if (stopPulseReg) begin
         stateReg <= ST_IDLE;
         busyReg <= 1'b0;
      end else begin
         case (stateReg)
            ST_IDLE: begin
               if (startPulseReg) begin
                  // config sampled once; later writes cannot disturb a run
                  radixLat <= radixReg;
                  baseWLat <= baseWReg;
                  pcReg <= {1'b0, opSelReg, 3'h0};
                  busyReg <= 1'b1;
                  stateReg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               instrReg <= microWord(pcReg);
               pcReg <= pcReg + 6'h1;
               stateReg <= ST_DECODE;
            end
            ST_DECODE: begin
               idxReg <= 8'h0;
               carryReg <= (opCode == `PKA_OP_SUB);
               if (opCode == `PKA_OP_END) begin
                  busyReg <= 1'b0;
                  stateReg <= ST_IDLE;
               end else if (radixLat == 8'h0) begin
                  stateReg <= ST_FETCH;
               end else begin
                  stateReg <= ST_READ;
               end
            end
            ST_READ: begin
               stateReg <= ST_EXEC;
            end
            ST_EXEC: begin
               carryReg <= sumW[32];
               idxReg <= idxReg + 8'h1;
               stateReg <= lastWord ? ST_FETCH : ST_READ;
            end
            default: begin
               stateReg <= ST_IDLE;
               busyReg <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // completion flags and interrupt
   // ************************************************************
   always @(posedge clk) begin
      if (!rst_n) begin
         doneReg <= 1'b0;
         abortReg <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (startPulseReg && !busyReg) begin
            doneReg <= 1'b0;
            abortReg <= 1'b0;
         end else begin
            // a finishing run beats a simultaneous software clear
            doneReg <= setDone | (doneReg & ~doneClr);
            abortReg <= (busyReg & stopPulseReg) | (abortReg & ~abortClr);
         end
         // enable only masks the line; flags run the same either way
         irq <= doneReg & irqEnReg;
      end
   end

   // ************************************************************
   // operand rams
   // ************************************************************
   reg [1:0] rdPhase;
   wire hostRdIssue = (rdPhase == RD_ADDR) && !wrCommit;
   wire [RAM_AW-1:0] hostIdx = wrCommit ? awOffA[RAM_AW+1:2] : arOffA[RAM_AW+1:2];
   wire [RAM_AW-1:0] hostIdxB = wrCommit ? awOffB[RAM_AW+1:2] : arOffB[RAM_AW+1:2];
   wire hostWeA = wrCommit & awHitA & awFull;
   wire hostWeB = wrCommit & awHitB & awFull;
   wire [31:0] hostDoutA;
   wire [31:0] hostDoutB;

   // words past the ten slots stay free for microcode scratch values
   pka_word_ram #(.AW(RAM_AW), .DEPTH(RAM_DEPTH)) ramFirst (
      .clk(clk),
      .hostAddr(hostIdx),
      .hostWe(hostWeA),
      .hostWdata(wDataReg),
      .hostRdata(hostDoutA),
      .engAddr(engAddrA),
      .engWe(engWeA),
      .engWdata(aluOut),
      .engRdata(engDoutA)
   );

   pka_word_ram #(.AW(RAM_AW), .DEPTH(RAM_DEPTH)) ramSecond (
      .clk(clk),
      .hostAddr(hostIdxB),
      .hostWe(hostWeB),
      .hostWdata(wDataReg),
      .hostRdata(hostDoutB),
      .engAddr(srcBAddr),
      .engWe(1'b0),
      .engWdata(32'h0),
      .engRdata(engDoutB)
   );

   // ************************************************************
   // axi read channel
   // ************************************************************
   reg [31:0] rdMux;
   reg [1:0] rdResp;
   always @* begin
      rdMux = 32'h0;
      rdResp = `PKA_RESP_OKAY;
      if (arHitA) begin
         rdMux = hostDoutA;
      end else if (arHitB) begin
         rdMux = hostDoutB;
      end else if (arAddrReg == `PKA_CTRL_ADDR) begin
         rdMux = 32'h0;
      end else if (arAddrReg == `PKA_CFG_ADDR) begin
         rdMux = {8'h0, radixReg, 7'h0, irqEnReg, 8'h0};
      end else if (arAddrReg == `PKA_MODE_ADDR) begin
         rdMux = {18'h0, opSelReg, 2'h0, curveReg, 5'h0, baseWReg};
      end else if (arAddrReg == `PKA_STAT_ADDR) begin
         rdMux = {28'h0, carryReg, abortReg, doneReg, busyReg};
      end else begin
         rdResp = `PKA_RESP_SLVERR;
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         rdPhase <= RD_IDLE;
         arAddrReg <= {`PKA_ADDR_W{1'b0}};
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `PKA_RESP_OKAY;
      end else begin
         case (rdPhase)
            RD_IDLE: begin
               if (s_axi_arvalid) begin
                  arAddrReg <= s_axi_araddr;
                  s_axi_arready <= 1'b0;
                  rdPhase <= RD_ADDR;
               end
            end
            RD_ADDR: begin
               // a write commit owns the host ram port this cycle
               if (hostRdIssue) begin
                  rdPhase <= RD_DATA;
               end
            end
            RD_DATA: begin
               s_axi_rdata <= rdMux;
               s_axi_rresp <= rdResp;
               s_axi_rvalid <= 1'b1;
               rdPhase <= RD_WAIT;
            end
            RD_WAIT: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rdPhase <= RD_IDLE;
               end
            end
            default: begin
               rdPhase <= RD_IDLE;
            end
         endcase
      end
   end
endmodule // pka_top

/* testbench/pka_top_checker.sv */
// concurrent checks on the bus and interrupt pins of the accelerator
`timescale 1ns/1ps
`include "pka_defines.vh"
module pka_top_checker #(
   parameter RAM_AW = 9,
   parameter RAM_DEPTH = 512
) (
   input wire clk,
   input wire rst_n,
   input wire [`PKA_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`PKA_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire awTake = s_axi_awvalid && s_axi_awready;
   wire wTake = s_axi_wvalid && s_axi_wready;
   wire arTake = s_axi_arvalid && s_axi_arready;
   // ************************************************************
   // assertions
   // ************************************************************
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before taken");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before taken");
   property p_b_lat;
      awTake && wTake |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat)
      else $error("write response late");
   property p_r_lat;
      arTake |=> !s_axi_rvalid ##[1:3] s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read data late");
   property p_ar_busy;
      arTake |=> !s_axi_arready [*2];
   endproperty
   a_ar_busy: assert property (p_ar_busy)
      else $error("second read accepted too early");
   property p_unmapped;
      arTake && s_axi_araddr >= 14'h2014 |->
         ##[2:4] (s_axi_rvalid && s_axi_rresp == `PKA_RESP_SLVERR && s_axi_rdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   // partial words must never reach operand ram a
   property p_strb_refuse;
      awTake && wTake && s_axi_awaddr >= `PKA_RAMA_BASE && s_axi_awaddr < 14'h0c00
         && s_axi_wstrb != `PKA_STRB_FULL |-> ##[1:2] (s_axi_bvalid
         && s_axi_bresp == `PKA_RESP_SLVERR);
   endproperty
   a_strb_refuse: assert property (p_strb_refuse)
      else $error("partial ram write not refused");
   property p_irq_fall;
      $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without host write");
   c_irq: cover property ($rose(irq));
   c_refuse: cover property (s_axi_bvalid && s_axi_bresp == `PKA_RESP_SLVERR);
   c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule // pka_top_checker

bind pka_top pka_top_checker #(.RAM_AW(RAM_AW), .RAM_DEPTH(RAM_DEPTH)) i_pka_top_checker (.*);

/* testbench/pka_host_model.sv */
// host bus master model: writes with any given strobe and reads with random response stalls
`timescale 1ns/1ps
module pka_host_model (
   input logic clk,
   output logic [13:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [13:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   end
   // ************************************************************
   // bus cycles
   // ************************************************************
   // strobe other than full only when probing a refusal
   task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
      bit gotA;
      bit gotW;
      gotA = 0;
      gotW = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      while (!(gotA && gotW)) begin
         @(posedge clk);
         // released lines flip so stale values cannot pass
         if (!gotA && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
            gotA = 1;
         end
         if (!gotW && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
            gotW = 1;
         end
      end
      repeat ($urandom_range(2)) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      repeat ($urandom_range(2)) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
endmodule // pka_host_model

/* testbench/test_pka_top.sv */
// self-checking bench: every microprogram on random operands, refusals, abort
`timescale 1ns/1ps
`include "pka_defines.vh"
module test_pka_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wire [`PKA_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   int errTotal = 0;
   int nTests = 0;
   logic [65:0] rq[$];
   logic [1:0] bq[$];
   logic [255:0] va0, va1, vb0, vb1, vb2, res;
   always #5 clk = ~clk;
   pka_top i_pka_top (.*);
   pka_host_model i_pka_host_model (.*);
   // ************************************************************
   // checking
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         errTotal++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   always @(posedge clk) begin
      logic [65:0] e;
      if (rst_n && s_axi_rvalid && s_axi_rready) begin
         e = rq.pop_front();
         check(s_axi_rdata & e[65:34], e[31:0]);
         check(32'(s_axi_rresp), 32'(e[33:32]));
      end
      if (rst_n && s_axi_bvalid && s_axi_bready) begin
         check(32'(s_axi_bresp), 32'(bq.pop_front()));
      end
   end
   task automatic wrx(input logic [13:0] a, input logic [31:0] d,
         input logic [3:0] s = `PKA_STRB_FULL, input logic [1:0] r = `PKA_RESP_OKAY);
      bq.push_back(r);
      i_pka_host_model.wr(a, d, s);
   endtask
   task automatic rdx(input logic [13:0] a, input logic [31:0] d,
         input logic [31:0] m = 32'hffffffff, input logic [1:0] r = `PKA_RESP_OKAY);
      rq.push_back({m, r, d});
      i_pka_host_model.rd(a);
   endtask
   // upper words stay zero so short operands are zero-filled
   task automatic load(input logic [13:0] base, input int n, output logic [255:0] v);
      v = '0;
      for (int i = 0; i < n; i++) begin
         v[32*i +: 32] = $urandom;
         wrx(base + 14'(4 * i), v[32*i +: 32]);
      end
   endtask
   task automatic waitIrq();
      for (int k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge clk);
      check(32'(irq), 32'h1);
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      int n;
      int dst;
      logic [2:0] bw;
      logic [13:0] sw;
      logic [31:0] mode;
      void'($urandom(41));
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdx(`PKA_STAT_ADDR, 32'h0, 32'h7);
      rdx(`PKA_CTRL_ADDR, 32'h0);
      rdx(`PKA_CFG_ADDR, 32'h0);
      rdx(`PKA_MODE_ADDR, 32'h2);
      rdx(14'h2100, 32'h0, 32'hffffffff, `PKA_RESP_SLVERR);
      rdx(14'h0c00, 32'h0, 32'hffffffff, `PKA_RESP_SLVERR);
      wrx(14'h2100, 32'h1, `PKA_STRB_FULL, `PKA_RESP_SLVERR);
      wrx(`PKA_RAMA_BASE, 32'h5a5a0f0f);
      wrx(`PKA_RAMA_BASE, 32'hffffffff, 4'h3, `PKA_RESP_SLVERR);
      rdx(`PKA_RAMA_BASE, 32'h5a5a0f0f);
      // each microprogram, walking the three slot strides
      for (int s = 0; s < 4; s++) begin
         bw = (s == 3) ? 3'h2 : 3'(2 + s);
         sw = (bw == 3'h2) ? 14'h24 : (bw == 3'h3) ? 14'h44 : 14'h84;
         n = (s == 0) ? 6 : $urandom_range(8, 1);
         load(`PKA_RAMA_BASE, n, va0);
         load(14'(`PKA_RAMA_BASE + sw), n, va1);
         load(`PKA_RAMB_BASE, n, vb0);
         load(14'(`PKA_RAMB_BASE + sw), n, vb1);
         load(14'(`PKA_RAMB_BASE + 2 * sw), n, vb2);
         mode = {18'h0, 2'(s), 2'h0, 2'(s), 5'h0, bw};
         wrx(`PKA_MODE_ADDR, mode);
         rdx(`PKA_MODE_ADDR, mode);
         wrx(`PKA_CFG_ADDR, {8'h0, 8'(n), 7'h0, 1'b1, 8'h0});
         wrx(`PKA_CTRL_ADDR, 32'h1);
         // count changed mid-run must not reach the running operation
         wrx(`PKA_CFG_ADDR, {8'h0, 8'h1, 7'h0, 1'b1, 8'h0});
         rdx(`PKA_CTRL_ADDR, 32'h0);
         waitIrq();
         rdx(`PKA_STAT_ADDR, 32'h2, 32'h7);
         res = (s == 0) ? va0 + vb0 : (s == 1) ? va0 - vb0 : (s == 2) ? va0 + vb0 - vb1 : va1 ^ vb2;
         dst = (s < 2) ? 2 : (s == 2) ? 4 : 6;
         for (int i = 0; i < n; i++) begin
            rdx(14'(`PKA_RAMA_BASE + dst * sw + 4 * i), res[32*i +: 32]);
         end
         wrx(`PKA_STAT_ADDR, 32'h6);
         repeat (2) @(posedge clk);
         check(32'(irq), 32'h0);
      end
      // abort in mid-run with the interrupt masked
      wrx(`PKA_MODE_ADDR, 32'h2002);
      wrx(`PKA_CFG_ADDR, 32'h00080000);
      wrx(`PKA_CTRL_ADDR, 32'h1);
      rdx(`PKA_STAT_ADDR, 32'h1, 32'h1);
      rdx(`PKA_RAMA_BASE, va0[31:0]);
      wrx(`PKA_CTRL_ADDR, 32'h10000);
      rdx(`PKA_STAT_ADDR, 32'h6, 32'h7);
      check(32'(irq), 32'h0);
      wrx(`PKA_CFG_ADDR, 32'h00080100);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h1);
      wrx(`PKA_STAT_ADDR, 32'h6);
      repeat (2) @(posedge clk);
      check(32'(irq), 32'h0);
      rdx(`PKA_STAT_ADDR, 32'h0, 32'h7);
      repeat (4) @(posedge clk);
      giveVerdict();
   end
   initial begin
      #400000;
      errTotal++;
      $display("ERROR %0t: watchdog expired", $time);
      giveVerdict();
   end
endmodule // test_pka_top
